// >>> rtl/psram_init_pkg.sv
// Purpose: Constants for the pseudo-static DRAM reset and init sequencer.
// Assumes: 250 MHz core clock, 4 ns period.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
// How it works
// - Self-initialization ends within 150 us, before a full array sweep completes.
// - Reset low at power-up delays init start.
// - Reset pulse of 200 ns returns standby.
// - Reset restores configuration registers to defaults.
// - Self-refresh halts while reset low, resumes after.
// - Reset returns refresh row counter to default.
package psram_init_pkg;
   localparam int CLK_PERIOD_PS          = 4000;   // Core clock period
   localparam int POWERUP_INIT_TIME_US   = 150;    // Longest init time
   localparam int RESET_PULSE_MIN_NS     = 200;    // Least reset pulse
   // Longest time rounds down
   localparam int POWERUP_INIT_CYCLES    =
      (POWERUP_INIT_TIME_US * 1000000) / CLK_PERIOD_PS;
   // Least time rounds up
   localparam int RESET_PULSE_CYCLES     =
      (RESET_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ROW_BITS               = 13;     // Refresh row counter
   localparam int CFG_WIDTH              = 16;     // Config register width
   localparam logic [12:0] ROW_DEFAULT   = 13'h0000; // Row counter reset
   localparam logic [15:0] CFG0_DEFAULT  = 16'h8F1F; // Config 0 default
   localparam logic [15:0] CFG1_DEFAULT  = 16'h0002; // Config 1 default
   localparam int REFRESH_GAP_CYCLES     = 16;     // Cycles between rows
   // Sequencer states, Gray coded along the path
   typedef enum logic [1:0] {
      ST_RESET   = 2'b00,                          // Reset held low
      ST_INIT    = 2'b01,                          // Array initialization
      ST_READY   = 2'b11                           // Standby, access allowed
   } seq_state_type;
endpackage : psram_init_pkg

// >>> rtl/psram_row_counter.sv
// Purpose: Refresh row counter with pacing divider.
// Assumes: Synchronous clear returns the row to its default.
// Notes:   Runs only while refresh is enabled.
`timescale 1ns/1ps
module psram_row_counter
   import psram_init_pkg::*;
#(
   parameter int ROWS_W = ROW_BITS,            // Row address width
   parameter int GAP    = REFRESH_GAP_CYCLES   // Cycles per row
) (
   input  wire logic              clk_in,       // Core clock
   input  wire logic              reset_n_in,   // Async reset, active low
   input  wire logic              ce_in,        // Clock enable
   input  wire logic              clear_in,     // Return to default row
   input  wire logic              run_in,       // Refresh enabled
   output logic [ROWS_W-1:0]      row_out,      // Current row
   output logic                   wrap_out      // One pulse at full sweep
);
   logic [7:0]        gap_r;                    // Pacing divider
   logic [ROWS_W-1:0] row_r;                    // Row register
   logic              wrap_r;                   // Sweep complete pulse
   wire               step = run_in && (gap_r == 8'(GAP - 1)); // Row step
   wire               last = &row_r;            // Last row reached

   ////////////////////////////////////////////////////////////////////////
   // Row and pacing update
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         gap_r  <= 8'h00;
         row_r  <= ROWS_W'(ROW_DEFAULT);
         wrap_r <= 1'b0;
      end else if (ce_in) begin
         if (clear_in) begin
            gap_r  <= 8'h00;
            row_r  <= ROWS_W'(ROW_DEFAULT);
            wrap_r <= 1'b0;
         end else begin
            gap_r  <= step ? 8'h00 : (run_in ? gap_r + 8'h01 : gap_r);
            row_r  <= step ? row_r + 1'b1 : row_r;
            wrap_r <= step && last;
         end
      end
   end
   assign row_out  = row_r;
   assign wrap_out = wrap_r;
endmodule : psram_row_counter

// >>> rtl/psram_reset_init_sequencer.sv
// Purpose: Device-side power-up and hardware reset sequencer.
// Assumes: Reset pin sampled synchronously; supply-ok from a sensor.
// Notes:   Init ends on full array sweep or on the longest init time.
`timescale 1ns/1ps
module psram_reset_init_sequencer
   import psram_init_pkg::*;
#(
   parameter int INIT_CYCLES  = POWERUP_INIT_CYCLES, // Init time limit
   parameter int PULSE_CYCLES = RESET_PULSE_CYCLES   // Least reset pulse
) (
   input  wire logic                 clk_in,         // Core clock
   input  wire logic                 reset_n_in,     // Async reset
   input  wire logic                 ce_in,          // Clock enable
   input  wire logic                 supply_ok_in,   // Supply at minimum
   input  wire logic                 pin_reset_n_in, // Reset pin, low
   input  wire logic                 cfg_wr_in,      // Config write strobe
   input  wire logic                 cfg_sel_in,     // Config 0 or 1
   input  wire logic [CFG_WIDTH-1:0] cfg_data_in,    // Config write data
   output logic                      ready_out,      // Access allowed
   output logic                      refresh_en_out, // Self-refresh active
   output logic [ROW_BITS-1:0]       row_out,        // Refresh row
   output logic [CFG_WIDTH-1:0]      cfg0_out,       // Config register 0
   output logic [CFG_WIDTH-1:0]      cfg1_out        // Config register 1
);
   seq_state_type         state_r, state_nxt;        // Sequencer state
   logic [17:0]           init_cnt_r;                // Init elapsed cycles
   logic [7:0]            low_cnt_r;                 // Reset low cycles
   logic                  ready_r;                   // Ready flag
   logic                  refresh_r;                 // Refresh enable
   logic [CFG_WIDTH-1:0]  cfg0_r, cfg1_r;            // Config registers
   logic [ROW_BITS-1:0]   row_w;                     // Row from counter
   logic                  wrap_w;                    // Sweep done

   // Reset is taken once low for the least pulse width
   wire pulse_ok  = low_cnt_r >= 8'(PULSE_CYCLES - 1);
   wire in_reset  = !supply_ok_in || (!pin_reset_n_in && pulse_ok);
   wire init_done = wrap_w || (init_cnt_r == 18'(INIT_CYCLES - 1));
   // Sequencer sits in reset; clears config and the row counter
   wire at_reset_st = (state_r == ST_RESET);

   ////////////////////////////////////////////////////////////////////////
   // Next state decode
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET: begin
            // Hold until supply good and reset pin high
            if (supply_ok_in && pin_reset_n_in)
               state_nxt = ST_INIT;
         end
         ST_INIT: begin
            if (in_reset)
               state_nxt = ST_RESET;
            else if (init_done)
               state_nxt = ST_READY;
         end
         ST_READY: begin
            if (in_reset)
               state_nxt = ST_RESET;
         end
         default: state_nxt = ST_RESET;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State, counters and flags
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r    <= ST_RESET;
         init_cnt_r <= 18'h00000;
         low_cnt_r  <= 8'h00;
         ready_r    <= 1'b0;
         refresh_r  <= 1'b0;
      end else if (ce_in) begin
         state_r    <= state_nxt;
         low_cnt_r  <= pin_reset_n_in ? 8'h00 :
                       (pulse_ok ? low_cnt_r : low_cnt_r + 8'h01);
         init_cnt_r <= (state_nxt == ST_INIT && state_r == ST_INIT) ?
                       init_cnt_r + 18'h00001 : 18'h00000;
         ready_r    <= (state_nxt == ST_READY);
         // Refresh stops while pin low, resumes on release
         refresh_r  <= supply_ok_in && pin_reset_n_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers, defaults restored by reset
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg0_r <= CFG0_DEFAULT;
         cfg1_r <= CFG1_DEFAULT;
      end else if (ce_in) begin
         if (at_reset_st) begin
            cfg0_r <= CFG0_DEFAULT;
            cfg1_r <= CFG1_DEFAULT;
         end else if (cfg_wr_in && ready_r) begin
            if (cfg_sel_in)
               cfg1_r <= cfg_data_in;
            else
               cfg0_r <= cfg_data_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Refresh row counter
   psram_row_counter u_rows (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .ce_in      (ce_in),
      .clear_in   (at_reset_st),
      .run_in     (refresh_r),
      .row_out    (row_w),
      .wrap_out   (wrap_w)
   );

   assign ready_out      = ready_r;
   assign refresh_en_out = refresh_r;
   assign row_out        = row_w;
   assign cfg0_out       = cfg0_r;
   assign cfg1_out       = cfg1_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_init_bound;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      (init_cnt_r == 18'(INIT_CYCLES - 1)) && state_r == ST_INIT
         && !in_reset |=> ready_r;
   endproperty
   a_init_bound: assert property (p_init_bound)
      else $error("Init exceeded longest time");

   property p_hold_reset;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      state_r == ST_RESET && !pin_reset_n_in |=> state_r == ST_RESET;
   endproperty
   a_hold_reset: assert property (p_hold_reset)
      else $error("Init started with reset pin low");

   property p_pulse;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      ready_r && supply_ok_in && !pin_reset_n_in && pulse_ok |=> !ready_r;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("Long reset pulse did not leave standby");

   property p_cfg_default;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      state_r == ST_RESET |=> cfg0_r == CFG0_DEFAULT
         && cfg1_r == CFG1_DEFAULT;
   endproperty
   a_cfg_default: assert property (p_cfg_default)
      else $error("Config not restored on reset");

   property p_refresh_halt;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      !pin_reset_n_in |=> !refresh_r;
   endproperty
   a_refresh_halt: assert property (p_refresh_halt)
      else $error("Refresh ran with reset pin low");

   property p_row_default;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      state_r == ST_RESET |=> row_w == ROW_BITS'(ROW_DEFAULT);
   endproperty
   a_row_default: assert property (p_row_default)
      else $error("Row counter not returned to default");

   // Init starts one edge after supply good and pin released
   property p_init_start;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      at_reset_st && supply_ok_in && pin_reset_n_in |=> state_r == ST_INIT;
   endproperty
   a_init_start: assert property (p_init_start)
      else $error("Init did not start after reset release");

   // A pin pulse below the least width leaves standby alone
   property p_short_pulse;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      ready_r && supply_ok_in && !pin_reset_n_in && !pulse_ok |=> ready_r;
   endproperty
   a_short_pulse: assert property (p_short_pulse)
      else $error("Short reset pulse left standby");

   // Supply loss drops access and returns to reset at once
   property p_supply_loss;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      !supply_ok_in |=> !ready_r && state_r == ST_RESET;
   endproperty
   a_supply_loss: assert property (p_supply_loss)
      else $error("Access allowed without supply");

   // Self-refresh runs whenever supply is good and pin high
   property p_refresh_resume;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      supply_ok_in && pin_reset_n_in |=> refresh_r;
   endproperty
   a_refresh_resume: assert property (p_refresh_resume)
      else $error("Refresh did not resume after pin release");

   // Row counter holds while refresh is halted outside the reset state
   property p_row_hold;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      !refresh_r && !at_reset_st |=> $stable(row_w);
   endproperty
   a_row_hold: assert property (p_row_hold)
      else $error("Row stepped while refresh halted");

   // Config is locked while init runs
   property p_cfg_locked;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      !ready_r && !at_reset_st |=> $stable(cfg0_r) && $stable(cfg1_r);
   endproperty
   a_cfg_locked: assert property (p_cfg_locked)
      else $error("Config changed during init");

   // Access flag stands only in standby
   property p_ready_state;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      ready_r |-> state_r == ST_READY;
   endproperty
   a_ready_state: assert property (p_ready_state)
      else $error("Access flag outside standby");

   // Init counter never passes the longest init time
   property p_init_count;
      @(posedge clk_in) disable iff (!reset_n_in || !ce_in)
      state_r == ST_INIT |-> init_cnt_r < 18'(INIT_CYCLES);
   endproperty
   a_init_count: assert property (p_init_count)
      else $error("Init counter passed its limit");

   // Clock enable low freezes the sequencer and the rows
   property p_freeze;
      @(posedge clk_in) disable iff (!reset_n_in)
      !ce_in |=> $stable(state_r) && $stable(low_cnt_r) && $stable(row_w);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("State moved with clock enable low");
endmodule : psram_reset_init_sequencer

// >>> dv/psram_host_model.sv
// Purpose: Host controller model driving supply, reset pin and config.
// Assumes: Drives on the falling edge of the 4 ns core clock.
// Notes:   Interval counts are rounded up to whole cycles.
`timescale 1ns/1ps
module psram_host_model (
   input  wire logic        clk_in,          // Core clock
   output logic             supply_ok_out,   // Supply at minimum
   output logic             pin_reset_n_out, // Reset pin, active low
   output logic             cfg_wr_out,      // Config write strobe
   output logic             cfg_sel_out,     // Config select
   output logic [15:0]      cfg_data_out     // Config write data
);
   localparam int REL_CYC  = 50;  // Release to select
   localparam int FALL_CYC = 100; // Fall to select
   int since_rel;                 // Cycles since pin went high
   int since_fall;                // Cycles since pin went low
   logic pin_q;                   // Pin level at the last edge
   initial begin
      supply_ok_out   = 1'b0;     // Select idle through power-up
      pin_reset_n_out = 1'b1;
      cfg_wr_out      = 1'b0;
      cfg_sel_out     = 1'b0;
      cfg_data_out    = 16'h0000;
      since_rel       = 0;
      since_fall      = 0;
      pin_q           = 1'b1;
   end
   // Interval counters for the select gap
   always @(posedge clk_in) begin
      since_rel  <= pin_reset_n_out ? since_rel + 1 : 0;
      since_fall <= (pin_q && !pin_reset_n_out) ? 0 : since_fall + 1;
      pin_q      <= pin_reset_n_out;
   end
   task automatic set_pin(input logic v);
      @(negedge clk_in);
      pin_reset_n_out = v;
   endtask : set_pin
   task automatic set_supply(input logic v);
      @(negedge clk_in);
      supply_ok_out = v;          // A dip is followed by a pin reset
   endtask : set_supply
   // Config write, never inside the reset gaps
   task automatic write_cfg(input logic s, input logic [15:0] d);
      while (since_rel < REL_CYC || since_fall < FALL_CYC)
         @(negedge clk_in);
      @(negedge clk_in);
      cfg_wr_out   = 1'b1;
      cfg_sel_out  = s;
      cfg_data_out = d;
      @(negedge clk_in);
      cfg_wr_out   = 1'b0;
      cfg_data_out = ~d;          // Stale data never lingers
   endtask : write_cfg
endmodule : psram_host_model

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the reset and init sequencer.
// Assumes: Short init of 100 cycles and reset pulse of 3 cycles.
// Notes:   Driver queues expectations, monitor compares them.
`timescale 1ns/1ps
`define CHK(g,e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
 $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
   import psram_init_pkg::*;
   typedef struct {int sel; logic [15:0] exp;} note_type;
   logic clk_in = 1'b0, reset_n_in = 1'b0, sup, pin, wr, sel, rdy, ref_en;
   logic ce = 1'b1;               // Clock enable, dropped once
   logic [15:0] data, c0, c1, d0, d1;
   logic [12:0] row;
   int bad_count = 0, n_compared = 0, cyc = 0, k;
   note_type q[$];
   event note_ev;
   always #2 clk_in = ~clk_in;    // 250 MHz core clock
   psram_host_model host (.clk_in(clk_in), .supply_ok_out(sup),
      .pin_reset_n_out(pin), .cfg_wr_out(wr), .cfg_sel_out(sel),
      .cfg_data_out(data));
   psram_reset_init_sequencer #(.INIT_CYCLES(100), .PULSE_CYCLES(3)) dut (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce),
      .supply_ok_in(sup), .pin_reset_n_in(pin), .cfg_wr_in(wr),
      .cfg_sel_in(sel), .cfg_data_in(data), .ready_out(rdy),
      .refresh_en_out(ref_en), .row_out(row), .cfg0_out(c0), .cfg1_out(c1));
   function automatic logic [15:0] pick(input int s);
      case (s)
         0: pick = {15'h0000, rdy};
         1: pick = {15'h0000, ref_en};
         2: pick = {3'h0, row};
         3: pick = c0;
         4: pick = c1;
         default: pick = {15'h0000, row != 13'h0000};
      endcase
   endfunction : pick
   task automatic note(input int s, input logic [15:0] e);
      q.push_back('{s, e});
      ->note_ev;
   endtask : note
   task automatic wait_ready(input int lim);
      for (k = 0; k < lim && rdy !== 1'b1; k++) @(negedge clk_in);
   endtask : wait_ready
   task automatic end_sim;
      if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   // Monitor drains the queue, oldest note first, and compares each with the outputs
   always @(note_ev) begin : mon
      note_type n;
      while (q.size() > 0) begin
         n = q.pop_front();
         `CHK(pick(n.sel), n.exp)
      end
   end
   // Hang guard
   always @(posedge clk_in) if (++cyc > 1000) begin
      bad_count++;
      end_sim();
   end
   initial begin
      d0 = 16'($urandom(32'hE175));
      d1 = 16'($urandom());
      host.set_pin(1'b0);
      host.set_supply(1'b1);
      repeat (16) @(negedge clk_in);
      reset_n_in = 1'b1;
      note(3, CFG0_DEFAULT); note(4, CFG1_DEFAULT);
      repeat (150) @(negedge clk_in);
      note(0, 16'h0000); note(1, 16'h0000);
      host.set_pin(1'b1);
      repeat (2) @(negedge clk_in);
      note(1, 16'h0001);
      repeat (93) @(negedge clk_in);
      note(0, 16'h0000);
      wait_ready(12);
      note(0, 16'h0001); note(5, 16'h0001);
      host.write_cfg(1'b0, d0);
      host.write_cfg(1'b1, d1);
      note(3, d0); note(4, d1);
      host.set_pin(1'b0);
      // Pin low for one or two samples, below the least width
      repeat ($urandom_range(1, 0)) @(negedge clk_in);
      host.set_pin(1'b1);
      note(1, 16'h0000);
      repeat (3) @(negedge clk_in);
      note(0, 16'h0001); note(3, d0);
      note(1, 16'h0001);
      host.set_pin(1'b0);
      repeat (5) @(negedge clk_in);
      note(0, 16'h0000); note(2, 16'h0000);
      note(3, CFG0_DEFAULT); note(4, CFG1_DEFAULT);
      host.set_pin(1'b1);
      // Deliberate write during init: the device must ignore it
      host.write_cfg(1'b0, ~d0);
      note(0, 16'h0000); note(3, CFG0_DEFAULT);
      wait_ready(20);
      note(0, 16'h0001); note(1, 16'h0001);
      // Contents count as lost after reset: reload the setting
      host.write_cfg(1'b0, d0);
      note(3, d0);
      // Enable low freezes state through a long pin pulse
      ce = 1'b0;
      host.set_pin(1'b0);
      repeat (5) @(negedge clk_in);
      note(0, 16'h0001); note(1, 16'h0001);
      host.set_pin(1'b1);
      ce = 1'b1;
      host.set_supply(1'b0);
      repeat (2) @(negedge clk_in);
      note(0, 16'h0000); note(1, 16'h0000);
      // Shallow dip: supply back, then a full pin pulse to re-init
      host.set_supply(1'b1);
      host.set_pin(1'b0);
      repeat (4) @(negedge clk_in);
      note(0, 16'h0000); note(3, CFG0_DEFAULT);
      host.set_pin(1'b1);
      wait_ready(120);
      note(0, 16'h0001); note(3, CFG0_DEFAULT);
      @(negedge clk_in);
      end_sim();
   end
endmodule : tb_top
